// ===== rtl/uart_rx_frame_detect_autobaud.v
// Function
// - frame start detect wakes from standby
// - data read clears receive complete flag
// - flag clear in active arms detector
// - detector start restarts current frame reception
// - start flag zero, no event in active
// - no frame while detector is re-enabled
// - autobaud modes flag bad sync field
// - bad sync halts receiver until re-enable
// - tx output direction drives high despite open drain
`timescale 1ns/1ps
`include "uart_rx_defs.vh"

module uart_rx_frame_detect_autobaud #(
	parameter DIV_W = 16
) (
	input  wire             clk,
	input  wire             rst_b,
	input  wire             rxd,
	input  wire             receiver_enable_bit,
	input  wire [1:0]       receiver_mode_field,
	input  wire             frame_start_detect_enable,
	input  wire             standby_mode,
	input  wire [DIV_W-1:0] baud_div,
	input  wire             data_read,
	input  wire             flag_clear,
	input  wire             sync_flag_clear,
	input  wire             tx_data,
	input  wire             tx_dir_out,
	input  wire             open_drain_mode,
	output reg  [7:0]       receive_data_regs,
	output reg              receive_complete_flag,
	output wire             receive_start_flag,
	output reg              bad_sync_field_flag,
	output wire             wake_request,
	output wire             rx_busy,
	output wire             txd_out,
	output wire             txd_oe
);

// ----------------------------------------
// state codes
// ----------------------------------------
localparam ST_IDLE  = 3'h0;
localparam ST_START = 3'h1;
localparam ST_DATA  = 3'h2;
localparam ST_STOP  = 3'h3;
localparam ST_SYNC  = 3'h4;
localparam ST_HALT  = 3'h5;

reg  [2:0]       state_reg;
reg  [DIV_W-1:0] cnt_reg;
reg  [DIV_W-1:0] div_reg;
reg  [3:0]       bit_reg;
reg  [7:0]       shift_reg;
reg              rxd_q_reg;
reg              armed_reg;
reg              rxs_reg;
reg              autobaud_done_reg;
reg  [DIV_W-1:0] sync_cnt_reg;
reg  [2:0]       edge_cnt_reg;

// ----------------------------------------
// line decode
// ----------------------------------------
// both auto-baud modes share the sync measurement; only the lin mode
// adds the bit time window, so the generic mode accepts any rate that gives a nonzero divisor before the sync counter saturates
wire autobaud   = (receiver_mode_field == `MODE_GEN_AUTO) ||
                  (receiver_mode_field == `MODE_LIN_AUTO);
// falling edge against the registered level; the register idles high
// after reset so no false edge follows it
wire fall       = rxd_q_reg & ~rxd;
wire half_tick  = (cnt_reg == {1'b0, div_reg[DIV_W-1:1]});
wire full_tick  = (cnt_reg == div_reg);
// detector restart only fires outside idle; in idle a fall starts normally
wire sfd_hit    = frame_start_detect_enable & armed_reg & fall &
                  (state_reg != ST_IDLE) & (state_reg != ST_HALT);
wire sync_bad;
wire [DIV_W-1:0] sync_div = sync_cnt_reg >> 3;

// ----------------------------------------
// tx pad: direction output drives both levels
// ----------------------------------------
// open drain only truly holds when software leaves direction as input
assign txd_out = tx_data;
assign txd_oe  = tx_dir_out | (open_drain_mode & ~tx_data);

// start flag reads zero outside standby
assign receive_start_flag = rxs_reg & standby_mode;
assign wake_request       = rxs_reg & standby_mode;
assign rx_busy            = (state_reg != ST_IDLE) && (state_reg != ST_HALT);

// lin mode also bounds the measured bit time
assign sync_bad = (sync_div == {DIV_W{1'b0}}) ||
                  ((receiver_mode_field == `MODE_LIN_AUTO) &&
                   ((sync_div < `LIN_DIV_MIN) || (sync_div > `LIN_DIV_MAX)));

// ----------------------------------------
// receive state machine
// ----------------------------------------
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		state_reg             <= ST_IDLE;
		cnt_reg               <= {DIV_W{1'b0}};
		div_reg               <= `DEF_BAUD_DIV;
		bit_reg               <= 4'h0;
		shift_reg             <= 8'h00;
		rxd_q_reg             <= 1'b1;
		armed_reg             <= 1'b0;
		rxs_reg               <= 1'b0;
		autobaud_done_reg     <= 1'b0;
		sync_cnt_reg          <= {DIV_W{1'b0}};
		edge_cnt_reg          <= 3'h0;
		receive_data_regs     <= 8'h00;
		receive_complete_flag <= 1'b0;
		bad_sync_field_flag   <= 1'b0;
	end else begin
		rxd_q_reg <= rxd;
		// sticky flag: set wins over clear
		if (sync_flag_clear)
			bad_sync_field_flag <= 1'b0;
		// flag clear by read or write; arming only in active mode
		if (data_read | flag_clear) begin
			receive_complete_flag <= 1'b0;
			if (!standby_mode)
				armed_reg <= 1'b1;
		end
		// detect enable low disarms; re-enabling mid frame does not re-arm, but in
		// standby the start flag sets on the next data edge, hence the quiet line rule
		if (!frame_start_detect_enable)
			armed_reg <= 1'b0;
		// start event only latched in standby, dropped on leaving
		if (!standby_mode)
			rxs_reg <= 1'b0;
		else if (frame_start_detect_enable && fall && receiver_enable_bit)
			rxs_reg <= 1'b1;
		if (!receiver_enable_bit) begin
			state_reg         <= ST_IDLE;
			autobaud_done_reg <= 1'b0;
			edge_cnt_reg      <= 3'h0;
			cnt_reg           <= {DIV_W{1'b0}};
		end else if (sfd_hit) begin
			// restart current frame from its start bit
			state_reg <= ST_START;
			cnt_reg   <= {DIV_W{1'b0}};
			bit_reg   <= 4'h0;
			armed_reg <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (fall) begin
					cnt_reg   <= {DIV_W{1'b0}};
					bit_reg   <= 4'h0;
					armed_reg <= 1'b0;
					if (autobaud && !autobaud_done_reg) begin
						state_reg    <= ST_SYNC;
						sync_cnt_reg <= {DIV_W{1'b0}};
						edge_cnt_reg <= 3'h0;
					end else begin
						div_reg   <= autobaud ? div_reg : baud_div;
						state_reg <= ST_START;
					end
				end
			end
			ST_SYNC: begin
				// measure eight bit times across the sync byte falling edges
				sync_cnt_reg <= sync_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
				if (fall) begin
					edge_cnt_reg <= edge_cnt_reg + 3'h1;
					if (edge_cnt_reg == 3'h3) begin
						if (sync_bad) begin
							bad_sync_field_flag <= 1'b1;
							state_reg           <= ST_HALT;
						end else begin
							div_reg           <= sync_div;
							autobaud_done_reg <= 1'b1;
							state_reg         <= ST_IDLE;
						end
					end
				end else if (&sync_cnt_reg) begin
					bad_sync_field_flag <= 1'b1;
					state_reg           <= ST_HALT;
				end
			end
			ST_START: begin
				cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
				if (half_tick) begin
					cnt_reg   <= {DIV_W{1'b0}};
					state_reg <= rxd ? ST_IDLE : ST_DATA;
				end
			end
			ST_DATA: begin
				cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
				if (full_tick) begin
					cnt_reg   <= {DIV_W{1'b0}};
					shift_reg <= {rxd, shift_reg[7:1]};
					bit_reg   <= bit_reg + 4'h1;
					if (bit_reg == `DATA_BITS - 4'h1)
						state_reg <= ST_STOP;
				end
			end
			ST_STOP: begin
				cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
				if (full_tick) begin
					receive_data_regs     <= shift_reg;
					receive_complete_flag <= 1'b1;
					state_reg             <= ST_IDLE;
				end
			end
			ST_HALT: begin
				// stays here until receiver enable drops; flag clear alone is not enough
				state_reg <= ST_HALT;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
end

endmodule // uart_rx_frame_detect_autobaud

// ===== rtl/uart_rx_defs.vh
`ifndef UART_RX_DEFS_VH
`define UART_RX_DEFS_VH

// ----------------------------------------
// receiver mode field encodings
// ----------------------------------------
`define MODE_NORMAL     2'h0
`define MODE_DOUBLE     2'h1
`define MODE_GEN_AUTO   2'h2
`define MODE_LIN_AUTO   2'h3

// ----------------------------------------
// frame shape and timing
// ----------------------------------------
`define DATA_BITS       4'h8
`define DEF_BAUD_DIV    16'h00d9
`define SYNC_BYTE       8'h55
`define LIN_DIV_MIN     16'h0019
`define LIN_DIV_MAX     16'h0a2c

`endif

// ===== testbench/uart_rx_checker_properties.sv
`timescale 1ns/1ps
// --
// port checker
// --
module uart_rx_checker (
	input       clk,
	input       rst_b,
	input       rxd,
	input       receiver_enable_bit,
	input [1:0] receiver_mode_field,
	input       frame_start_detect_enable,
	input       standby_mode,
	input       data_read,
	input       flag_clear,
	input [7:0] receive_data_regs,
	input       receive_complete_flag,
	input       receive_start_flag,
	input       bad_sync_field_flag,
	input       wake_request,
	input       rx_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_quiet; !standby_mode |-> !receive_start_flag && !wake_request; endproperty
	a_quiet: assert property (p_quiet) else $error("start flag active");
	property p_wake; standby_mode && frame_start_detect_enable && $fell(rxd) |-> ##[1:3] wake_request;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_clr; (data_read || flag_clear) && !rx_busy |=> !receive_complete_flag; endproperty
	a_clr: assert property (p_clr) else $error("flag kept");
	property p_hold; receive_complete_flag && !data_read && !flag_clear |=> receive_complete_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_data; $changed(receive_data_regs) |-> receive_complete_flag; endproperty
	a_data: assert property (p_data) else $error("data no flag");
	property p_mode; $rose(bad_sync_field_flag) |-> receiver_mode_field[1]; endproperty
	a_mode: assert property (p_mode) else $error("bad sync mode");
	// reception stays dead while the sync error stands
	property p_halt; bad_sync_field_flag |-> !$rose(receive_complete_flag); endproperty
	a_halt: assert property (p_halt) else $error("rx after bad sync");
	property p_idle; !receiver_enable_bit |=> !rx_busy; endproperty
	a_idle: assert property (p_idle) else $error("busy when off");
endmodule // uart_rx_checker

// ===== testbench/serial_node.sv
`timescale 1ns/1ps
// --
// remote node
// --
module serial_node (
	input      clk,
	output reg line
);
	// idle high; start, eight bits lsb first, stop, 16 cycles each
	initial line = 1'h1;
	task frame(input [7:0] b);
		reg     [9:0] s;
		integer       i;
		s = {1'h1, b, 1'h0};
		for (i = 0; i < 10; i = i + 1) begin
			line = s[i];
			repeat (16) @(negedge clk);
		end
	endtask
endmodule // serial_node

// ===== testbench/uart_rx_frame_detect_autobaud_bench.sv
`timescale 1ns/1ps
// --
// bench
// --
module uart_rx_frame_detect_autobaud_bench;
	reg        clk = 1'h0, rst_b = 1'h0, data_read = 1'h0, flag_clear = 1'h0, old = 1'h0;
	reg        sync_flag_clear = 1'h0, receiver_enable_bit = 1'h0, standby_mode = 1'h0;
	reg        frame_start_detect_enable = 1'h0, tx_data = 1'h0, tx_dir_out = 1'h0;
	reg        open_drain_mode = 1'h0;
	reg  [1:0] receiver_mode_field = 2'h0;
	reg [15:0] baud_div = 16'h000f;
	reg  [7:0] exp_q[$];
	wire       rxd, receive_complete_flag, receive_start_flag, bad_sync_field_flag;
	wire       wake_request, rx_busy, txd_out, txd_oe;
	wire [7:0] receive_data_regs;
	integer    n_errors = 0, samples_checked = 0, i;
	serial_node node (.clk(clk), .line(rxd));
	uart_rx_frame_detect_autobaud dut (.*);
	// 25 MHz clock
	always #20 clk = ~clk;
	task check(input [7:0] got, input [7:0] want, input [39:0] what);
		samples_checked = samples_checked + 1;
		if (got !== want) begin
			n_errors = n_errors + 1;
			$display("wrong value %0s expected %h seen %h", what, want, got);
		end
	endtask
	task read_out;
		repeat (4) @(negedge clk);
		data_read = 1'h1;
		@(negedge clk) data_read = 1'h0;
		check(receive_complete_flag, 8'h00, "done");
	endtask
	task rx(input [7:0] v);
		exp_q.push_back(v);
		node.frame(v);
		read_out;
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// each finished frame meets the oldest note
	always @(negedge clk) begin
		if (receive_complete_flag && !old && exp_q.size() > 0)
			check(receive_data_regs, exp_q.pop_front(), "data");
		old = receive_complete_flag;
	end
	// tests take about 1800 cycles; this only trips on a hang
	initial begin
		#200000;
		n_errors = n_errors + 1;
		give_verdict;
	end
	// main sequence
	initial begin
		i = $urandom(32'h8536);
		repeat (2) @(negedge clk);
		rst_b = 1'h1;
		receiver_enable_bit = 1'h1;
		for (i = 0; i < 4; i = i + 1) begin
			receiver_mode_field = {1'h0, i[0]};
			rx(8'($urandom));
		end
		$display("test 1 end");
		frame_start_detect_enable = 1'h1;
		exp_q.push_back(8'hfe);
		fork
			node.frame(8'h3c);
			begin
				repeat (80) @(negedge clk);
				flag_clear = 1'h1;
				@(negedge clk) flag_clear = 1'h0;
				check(receive_start_flag, 8'h00, "start");
			end
		join
		repeat (116) @(negedge clk);
		read_out;
		standby_mode = 1'h1;
		exp_q.push_back(8'h5a);
		node.frame(8'h5a);
		check(wake_request, 8'h01, "wake");
		read_out;
		standby_mode = 1'h0;
		frame_start_detect_enable = 1'h0;
		@(negedge clk);
		check(wake_request, 8'h00, "wake");
		$display("test 2 end");
		for (i = 2; i < 4; i = i + 1) begin
			receiver_enable_bit = 1'h0;
			receiver_mode_field = i[1:0];
			@(negedge clk) receiver_enable_bit = 1'h1;
			node.frame(8'h55);
			check(bad_sync_field_flag, {7'h00, i[0]}, "bad");
			read_out;
		end
		sync_flag_clear = 1'h1;
		@(negedge clk) sync_flag_clear = 1'h0;
		node.frame(8'h81);
		check(receive_complete_flag, 8'h00, "halt");
		receiver_enable_bit = 1'h0;
		receiver_mode_field = 2'h0;
		@(negedge clk) receiver_enable_bit = 1'h1;
		rx(8'($urandom));
		$display("test 3 end");
		for (i = 0; i < 8; i = i + 1) begin
			{open_drain_mode, tx_dir_out, tx_data} = i[2:0];
			@(negedge clk);
			check({txd_out, txd_oe}, {i[0], i[1] | (i[2] & ~i[0])}, "txd");
		end
		$display("test 4 end");
		give_verdict;
	end
endmodule // uart_rx_frame_detect_autobaud_bench

bind uart_rx_frame_detect_autobaud uart_rx_checker chk (.*);
